// ---- verilog/svp_pkg.sv ----
// svp_pkg: register map, field layouts and codes for the ingress classifier.
// assumes a single 20 MHz core clock and a plain strobe register port.
package svp_pkg;
    localparam int NPORT       = 3;
    localparam int NVLAN       = 16;
    localparam int VID_W       = 12;
    localparam int PRIO_W      = 3;
    localparam int QUEUE_W     = 2;
    localparam int DSCP_W      = 6;
    localparam int DSCP_DEPTH  = 64;
    localparam int ADDR_W      = 8;
    localparam int DATA_W      = 32;
    localparam int VIDX_W      = 5;

    // register byte addresses
    localparam logic [7:0] REG_GLOBAL_CFG   = 8'h00;
    localparam logic [7:0] REG_TREE_STATE   = 8'h04;
    localparam logic [7:0] REG_DSCP_CMD     = 8'h08;
    localparam logic [7:0] REG_DSCP_WDATA   = 8'h0C;
    localparam logic [7:0] REG_DSCP_RDATA   = 8'h10;
    localparam logic [7:0] REG_CMD_STATUS   = 8'h14;
    localparam logic [7:0] REG_REGEN_P0     = 8'h18;
    localparam logic [7:0] REG_REGEN_P1     = 8'h1C;
    localparam logic [7:0] REG_REGEN_P2     = 8'h20;
    localparam logic [7:0] REG_VLAN_CMD     = 8'h24;
    localparam logic [7:0] REG_VLAN_WDATA   = 8'h28;
    localparam logic [7:0] REG_VLAN_RDATA   = 8'h2C;
    localparam logic [7:0] REG_TC_MAP       = 8'h30;
    localparam logic [7:0] REG_HYBRID       = 8'h34;
    localparam logic [7:0] REG_LAST_RESULT  = 8'h38;

    // global configuration bits
    localparam int CFG_DSCP_SEL  = 0;
    localparam int CFG_TAG_SEL   = 1;
    localparam int CFG_TAG_DIS   = 2;
    localparam int CFG_MBR_CHK   = 3;
    localparam int CFG_VLAN_EN   = 4;
    localparam int CFG_W         = 5;

    // command register fields
    localparam int CMD_WRITE_BIT = 8;
    localparam int VENT_MBR_LO   = 12;
    localparam int VENT_UNT_LO   = 15;
    localparam int VENT_VALID    = 18;
    localparam int VENT_W        = 19;
    localparam int PORT_DEFAULT_VLAN_ID_PRIO_LO  = 12;
    localparam logic [VIDX_W-1:0] PORT_DEFAULT_VLAN_ID_IDX_BASE = 5'h10;

    localparam logic [VID_W-1:0] VID_NULL = 12'h000;
    localparam logic [VID_W-1:0] VID_RSVD = 12'hFFF;

    // spanning tree port states
    localparam logic [1:0] ST_FORWARD  = 2'h0;
    localparam logic [1:0] ST_BLOCK    = 2'h1;
    localparam logic [1:0] ST_LEARN    = 2'h2;
    localparam logic [1:0] ST_DISABLE  = 2'h3;

    localparam logic [15:0] TC_MAP_RST = 16'hFA50;
    // identity regeneration: tag priority n maps to n
    localparam logic [23:0] REGEN_RST  = 24'hFAC688;
    localparam logic [VID_W-1:0] PORT_DEFAULT_VLAN_ID_RST = 12'h001;

    typedef enum logic [2:0] {
        CMD_IDLE   = 3'b001,
        CMD_ACCESS = 3'b010,
        CMD_DONE   = 3'b100
    } svp_cmd_e;
endpackage

// ---- verilog/svp_dscp_mem.sv ----
// svp_dscp_mem: codepoint priority table, one write port, two read ports.
// assumes contents are loaded by software; no reset of the array itself.
`timescale 1ns/100ps
`default_nettype none
module svp_dscp_mem (
    input  wire logic                          core_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          wr_en,
    input  wire logic [svp_pkg::DSCP_W-1:0]    wr_addr,
    input  wire logic [svp_pkg::PRIO_W-1:0]    wr_data,
    input  wire logic [svp_pkg::DSCP_W-1:0]    rd_a_addr,
    output logic      [svp_pkg::PRIO_W-1:0]    rd_a_data,
    input  wire logic [svp_pkg::DSCP_W-1:0]    rd_b_addr,
    output logic      [svp_pkg::PRIO_W-1:0]    rd_b_data
);
    import svp_pkg::*;

    logic [PRIO_W-1:0] mem [DSCP_DEPTH];

    // left uninitialised on purpose
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_a_data <= '0;
            rd_b_data <= '0;
        end else begin
            rd_a_data <= mem[rd_a_addr];
            rd_b_data <= mem[rd_b_addr];
        end
    end
endmodule
`default_nettype wire

// ---- verilog/svp_classifier.sv ----
// svp_classifier: ingress priority, vlan and spanning tree classification.
// assumes packet descriptors come from port macs on core_clk, already parsed.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - codepoint mode: upper six tos bits index table, entry is priority
// - codepoint priority goes through traffic class map to pick queue
// - codepoint works tagged or untagged, any encapsulation
// - tag mode: tag priority remapped through ingress port regeneration table
// - sixteen vlan entries of vid, membership and untag sets
// - tag vid not 000 or FFF searches table; hit gives membership
// - miss gives empty membership; dropped when membership check on
// - empty membership drops packet when destination address unknown
// - untagged or vid 0 takes port default vid and priority
// - tag vlan disable forces port default vid always
// - membership gates egress; untag applied only on hybrid ports
// - disabled state: drop rx, never tx, no learning
// - blocking/listening: rx and tx dropped unless override, no learning
// - learning state: rx and tx dropped unless override, learning on
// - forwarding state: normal rx, tx and learning
// - blocking and learning ports transmit only override packets
// - any priority maps through traffic class table to four queues
module svp_classifier (
    input  wire logic                          core_clk,
    input  wire logic                          sys_rst,
    input  wire logic [svp_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [svp_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [svp_pkg::DATA_W-1:0]    reg_rdata,
    input  wire logic                          pkt_valid,
    input  wire logic [1:0]                    pkt_port,
    input  wire logic                          pkt_tagged,
    input  wire logic [svp_pkg::VID_W-1:0]     pkt_vid,
    input  wire logic [svp_pkg::PRIO_W-1:0]    pkt_pcp,
    input  wire logic                          pkt_is_ip,
    input  wire logic [7:0]                    pkt_tos,
    input  wire logic                          pkt_da_hit,
    input  wire logic                          pkt_da_override,
    output logic                               res_valid,
    output logic                               res_drop,
    output logic      [svp_pkg::PRIO_W-1:0]    res_prio,
    output logic      [svp_pkg::QUEUE_W-1:0]   res_queue,
    output logic      [svp_pkg::VID_W-1:0]     res_vid,
    output logic      [svp_pkg::NPORT-1:0]     res_member,
    output logic      [svp_pkg::NPORT-1:0]     res_untag,
    output logic      [svp_pkg::NPORT-1:0]     res_egress,
    output logic                               res_learn
);
    import svp_pkg::*;

    function automatic logic tx_ok(input logic [1:0] st, input logic ovr);
        tx_ok = (st == ST_FORWARD) || (ovr && (st != ST_DISABLE));
    endfunction

    function automatic logic [1:0] st_of(input logic [5:0] all, input logic [1:0] p);
        st_of = all[2*p +: 2];
    endfunction

    // configuration and tables
    logic [CFG_W-1:0]        cfg_r;
    logic [2*NPORT-1:0]      tree_state_r;
    logic [8:0]              dscp_cmd_r;
    logic [PRIO_W-1:0]       dscp_wdata_r;
    logic [PRIO_W-1:0]       dscp_rdata_r;
    logic [23:0]             regen_r [NPORT];
    logic [8:0]              vlan_cmd_r;
    logic [VENT_W-1:0]       vlan_wdata_r;
    logic [VENT_W-1:0]       vlan_rdata_r;
    logic [15:0]             tc_map_r;
    logic [NPORT-1:0]        hybrid_r;
    logic [VID_W-1:0]        vt_vid_r  [NVLAN];
    logic [NPORT-1:0]        vt_mbr_r  [NVLAN];
    logic [NPORT-1:0]        vt_unt_r  [NVLAN];
    logic [NVLAN-1:0]        vt_val_r;
    logic [VID_W-1:0]        port_default_vlan_id_r    [NPORT];
    logic [PRIO_W-1:0]       port_default_vlan_id_pri_r[NPORT];
    svp_cmd_e                cmd_r;
    logic                    cmd_vlan_r;
    logic [DATA_W-1:0]       reg_rdata_nxt;

    // register decode
    wire wr_cfg    = reg_wr && (reg_addr == REG_GLOBAL_CFG);
    wire wr_state  = reg_wr && (reg_addr == REG_TREE_STATE);
    wire wr_dcmd   = reg_wr && (reg_addr == REG_DSCP_CMD);
    wire wr_dwd    = reg_wr && (reg_addr == REG_DSCP_WDATA);
    wire wr_vcmd   = reg_wr && (reg_addr == REG_VLAN_CMD);
    wire wr_vwd    = reg_wr && (reg_addr == REG_VLAN_WDATA);
    wire wr_tc     = reg_wr && (reg_addr == REG_TC_MAP);
    wire wr_hyb    = reg_wr && (reg_addr == REG_HYBRID);
    wire cmd_idle  = (cmd_r == CMD_IDLE);
    wire cmd_busy  = !cmd_idle;
    // commands written while busy are ignored
    wire cmd_start = cmd_idle && (wr_dcmd || wr_vcmd);

    wire [VIDX_W-1:0] v_idx   = vlan_cmd_r[VIDX_W-1:0];
    wire              v_write = vlan_cmd_r[CMD_WRITE_BIT];
    wire              v_is_pv = (v_idx >= PORT_DEFAULT_VLAN_ID_IDX_BASE);
    wire [1:0]        pv_idx  = 2'(v_idx - PORT_DEFAULT_VLAN_ID_IDX_BASE);
    // indices past the last port default are refused, not aliased
    wire              v_pv_ok = v_is_pv && (v_idx < PORT_DEFAULT_VLAN_ID_IDX_BASE + VIDX_W'(NPORT));
    wire [3:0]        vt_idx  = v_idx[3:0];
    wire              v_acc   = (cmd_r == CMD_ACCESS) && cmd_vlan_r;
    wire              d_mem_we = (cmd_r == CMD_ACCESS) && !cmd_vlan_r && dscp_cmd_r[CMD_WRITE_BIT];

    logic [PRIO_W-1:0] host_rd_prio;
    logic [PRIO_W-1:0] cls_dscp_prio;

    // stage 1: descriptor capture
    logic                s1_valid_r;
    logic [1:0]          s1_port_r;
    logic                s1_tagged_r;
    logic [VID_W-1:0]    s1_vid_r;
    logic [PRIO_W-1:0]   s1_pcp_r;
    logic                s1_is_ip_r;
    logic                s1_da_hit_r;
    logic                s1_ovr_r;

    // codepoint field is the upper six tos bits, encapsulation already stripped
    svp_dscp_mem svp_dscp_mem_inst (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .wr_en     (d_mem_we),
        .wr_addr   (dscp_cmd_r[DSCP_W-1:0]),
        .wr_data   (dscp_wdata_r),
        .rd_a_addr (dscp_cmd_r[DSCP_W-1:0]),
        .rd_a_data (host_rd_prio),
        .rd_b_addr (pkt_tos[7:8-DSCP_W]),
        .rd_b_data (cls_dscp_prio)
    );

    // command engine
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_r      <= CMD_IDLE;
            cmd_vlan_r <= 1'b0;
        end else begin
            unique case (cmd_r)
                CMD_IDLE: begin
                    if (cmd_start) begin
                        cmd_r      <= CMD_ACCESS;
                        cmd_vlan_r <= wr_vcmd;
                    end
                end
                CMD_ACCESS: cmd_r <= CMD_DONE;
                CMD_DONE:   cmd_r <= CMD_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_r        <= '0;
            tree_state_r <= '0;
            dscp_cmd_r   <= '0;
            dscp_wdata_r <= '0;
            vlan_cmd_r   <= '0;
            vlan_wdata_r <= '0;
            tc_map_r     <= TC_MAP_RST;
            hybrid_r     <= '0;
        end else begin
            if (wr_cfg)   cfg_r        <= reg_wdata[CFG_W-1:0];
            if (wr_state) tree_state_r <= reg_wdata[2*NPORT-1:0];
            if (wr_dcmd && cmd_idle) dscp_cmd_r <= reg_wdata[8:0];
            if (wr_dwd)   dscp_wdata_r <= reg_wdata[PRIO_W-1:0];
            if (wr_vcmd && cmd_idle) vlan_cmd_r <= reg_wdata[8:0];
            if (wr_vwd)   vlan_wdata_r <= reg_wdata[VENT_W-1:0];
            if (wr_tc)    tc_map_r     <= reg_wdata[15:0];
            if (wr_hyb)   hybrid_r     <= reg_wdata[NPORT-1:0];
        end
    end

    // regeneration tables, one register per ingress port
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int p = 0; p < NPORT; p++) begin
                regen_r[p] <= REGEN_RST;
            end
        end else begin
            if (reg_wr && reg_addr == REG_REGEN_P0) regen_r[0] <= reg_wdata[23:0];
            if (reg_wr && reg_addr == REG_REGEN_P1) regen_r[1] <= reg_wdata[23:0];
            if (reg_wr && reg_addr == REG_REGEN_P2) regen_r[2] <= reg_wdata[23:0];
        end
    end

    // vlan table and port defaults
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vt_val_r <= '0;
            for (int i = 0; i < NVLAN; i++) begin
                vt_vid_r[i] <= '0;
                vt_mbr_r[i] <= '0;
                vt_unt_r[i] <= '0;
            end
            for (int p = 0; p < NPORT; p++) begin
                port_default_vlan_id_r[p]     <= PORT_DEFAULT_VLAN_ID_RST;
                port_default_vlan_id_pri_r[p] <= '0;
            end
        end else if (v_acc && v_write) begin
            if (v_pv_ok) begin
                port_default_vlan_id_r[pv_idx]     <= vlan_wdata_r[VID_W-1:0];
                port_default_vlan_id_pri_r[pv_idx] <= vlan_wdata_r[PORT_DEFAULT_VLAN_ID_PRIO_LO +: PRIO_W];
            end else if (!v_is_pv) begin
                vt_vid_r[vt_idx]  <= vlan_wdata_r[VID_W-1:0];
                vt_mbr_r[vt_idx]  <= vlan_wdata_r[VENT_MBR_LO +: NPORT];
                vt_unt_r[vt_idx]  <= vlan_wdata_r[VENT_UNT_LO +: NPORT];
                vt_val_r[vt_idx]  <= vlan_wdata_r[VENT_VALID];
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vlan_rdata_r <= '0;
            dscp_rdata_r <= '0;
        end else begin
            if (v_acc && !v_write) begin
                vlan_rdata_r <= v_pv_ok ? VENT_W'({port_default_vlan_id_pri_r[pv_idx], port_default_vlan_id_r[pv_idx]})
                              : v_is_pv ? '0
                                        : {vt_val_r[vt_idx], vt_unt_r[vt_idx], vt_mbr_r[vt_idx], vt_vid_r[vt_idx]};
            end
            if ((cmd_r == CMD_DONE) && !cmd_vlan_r) dscp_rdata_r <= host_rd_prio;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_valid_r  <= 1'b0;
            s1_port_r   <= '0;
            s1_tagged_r <= 1'b0;
            s1_vid_r    <= '0;
            s1_pcp_r    <= '0;
            s1_is_ip_r  <= 1'b0;
            s1_da_hit_r <= 1'b0;
            s1_ovr_r    <= 1'b0;
        end else begin
            s1_valid_r  <= pkt_valid;
            s1_port_r   <= pkt_port;
            s1_tagged_r <= pkt_tagged;
            s1_vid_r    <= pkt_vid;
            s1_pcp_r    <= pkt_pcp;
            s1_is_ip_r  <= pkt_is_ip;
            s1_da_hit_r <= pkt_da_hit;
            s1_ovr_r    <= pkt_da_override;
        end
    end

    // stage 2: classification
    wire [1:0] src_st   = st_of(tree_state_r, s1_port_r);
    wire       use_port_default_vlan_id = cfg_r[CFG_TAG_DIS] || !s1_tagged_r || (s1_vid_r == VID_NULL);
    wire [VID_W-1:0] eff_vid = use_port_default_vlan_id ? port_default_vlan_id_r[s1_port_r] : s1_vid_r;
    wire       vid_rsvd = s1_tagged_r && !use_port_default_vlan_id && (s1_vid_r == VID_RSVD);
    wire [PRIO_W-1:0] regen_prio = regen_r[s1_port_r][PRIO_W*s1_pcp_r +: PRIO_W];

    logic [NVLAN-1:0] vt_hit;
    always_comb begin
        for (int i = 0; i < NVLAN; i++) begin
            vt_hit[i] = vt_val_r[i] && (vt_vid_r[i] == eff_vid);
        end
    end

    logic [NPORT-1:0] hit_mbr;
    logic [NPORT-1:0] hit_unt;
    always_comb begin
        hit_mbr = '0;
        hit_unt = '0;
        for (int i = 0; i < NVLAN; i++) begin
            if (vt_hit[i]) begin
                hit_mbr = hit_mbr | vt_mbr_r[i];
                hit_unt = hit_unt | vt_unt_r[i];
            end
        end
    end

    // a miss leaves the membership empty
    wire [NPORT-1:0] mbr_set = vid_rsvd ? '0 : hit_mbr;
    wire vlan_en   = cfg_r[CFG_VLAN_EN];
    wire mbr_fail  = vlan_en && cfg_r[CFG_MBR_CHK] && !mbr_set[s1_port_r];
    wire null_fail = vlan_en && (mbr_set == '0) && !s1_da_hit_r;

    wire [PRIO_W-1:0] sel_prio = (cfg_r[CFG_DSCP_SEL] && s1_is_ip_r) ? cls_dscp_prio :
                                 (cfg_r[CFG_TAG_SEL] && s1_tagged_r && !use_port_default_vlan_id) ? regen_prio :
                                 port_default_vlan_id_pri_r[s1_port_r];
    wire [QUEUE_W-1:0] sel_queue = tc_map_r[QUEUE_W*sel_prio +: QUEUE_W];

    logic [NPORT-1:0] tx_allow;
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            tx_allow[p] = tx_ok(st_of(tree_state_r, 2'(p)), s1_ovr_r);
        end
    end

    wire rx_drop   = !tx_ok(src_st, s1_ovr_r);
    wire learn_ok  = (src_st == ST_FORWARD) || (src_st == ST_LEARN);
    wire [NPORT-1:0] dom_set = vlan_en ? mbr_set : {NPORT{1'b1}};
    wire [NPORT-1:0] egress  = dom_set & tx_allow & ~(NPORT'(1) << s1_port_r);
    wire drop_nxt = rx_drop || mbr_fail || null_fail || (vlan_en && vid_rsvd);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            res_valid  <= 1'b0;
            res_drop   <= 1'b0;
            res_prio   <= '0;
            res_queue  <= '0;
            res_vid    <= '0;
            res_member <= '0;
            res_untag  <= '0;
            res_egress <= '0;
            res_learn  <= 1'b0;
        end else begin
            res_valid  <= s1_valid_r;
            if (s1_valid_r) begin
                res_drop   <= drop_nxt;
                res_prio   <= sel_prio;
                res_queue  <= sel_queue;
                res_vid    <= eff_vid;
                res_member <= mbr_set;
                res_untag  <= mbr_set & hit_unt & hybrid_r;
                res_egress <= drop_nxt ? '0 : egress;
                res_learn  <= learn_ok;
            end
        end
    end

    // register read, data one cycle after the strobe
    always_comb begin
        unique case (reg_addr)
            REG_GLOBAL_CFG:  reg_rdata_nxt = DATA_W'(cfg_r);
            REG_TREE_STATE:  reg_rdata_nxt = DATA_W'(tree_state_r);
            REG_DSCP_CMD:    reg_rdata_nxt = DATA_W'(dscp_cmd_r);
            REG_DSCP_WDATA:  reg_rdata_nxt = DATA_W'(dscp_wdata_r);
            REG_DSCP_RDATA:  reg_rdata_nxt = DATA_W'(dscp_rdata_r);
            REG_CMD_STATUS:  reg_rdata_nxt = DATA_W'(cmd_busy);
            REG_REGEN_P0:    reg_rdata_nxt = DATA_W'(regen_r[0]);
            REG_REGEN_P1:    reg_rdata_nxt = DATA_W'(regen_r[1]);
            REG_REGEN_P2:    reg_rdata_nxt = DATA_W'(regen_r[2]);
            REG_VLAN_CMD:    reg_rdata_nxt = DATA_W'(vlan_cmd_r);
            REG_VLAN_WDATA:  reg_rdata_nxt = DATA_W'(vlan_wdata_r);
            REG_VLAN_RDATA:  reg_rdata_nxt = DATA_W'(vlan_rdata_r);
            REG_TC_MAP:      reg_rdata_nxt = DATA_W'(tc_map_r);
            REG_HYBRID:      reg_rdata_nxt = DATA_W'(hybrid_r);
            REG_LAST_RESULT: reg_rdata_nxt = DATA_W'({res_learn, res_drop, res_queue, res_prio});
            default:         reg_rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= reg_rdata_nxt;
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    wire [1:0] in_st = st_of(tree_state_r, pkt_port);

    sequence seq_cmd_run;
        cmd_busy ##1 cmd_busy ##1 !cmd_busy;
    endsequence

    AST_CMD_DONE: assert property (cmd_start |=> seq_cmd_run) else $error("command not done in two cycles");
    AST_DSCP_PRIO: assert property (s1_valid_r && cfg_r[CFG_DSCP_SEL] && s1_is_ip_r && $stable(cfg_r)
        |=> res_prio == $past(cls_dscp_prio)) else $error("codepoint priority not used");
    AST_QUEUE_MAP: assert property (res_valid && $stable(tc_map_r)
        |-> res_queue == tc_map_r[QUEUE_W*res_prio +: QUEUE_W]) else $error("queue not from class map");
    AST_DISABLED_RX: assert property (pkt_valid && in_st == ST_DISABLE && $stable(tree_state_r)
        |-> ##2 res_valid && res_drop && !res_learn) else $error("disabled port not dropped");
    AST_DISABLED_TX: assert property (res_valid && $stable(tree_state_r)
        |-> (res_egress & {tree_state_r[5] & tree_state_r[4], tree_state_r[3] & tree_state_r[2],
             tree_state_r[1] & tree_state_r[0]}) == '0) else $error("egress to disabled port");
    AST_BLOCK_NOLEARN: assert property (pkt_valid && in_st == ST_BLOCK && $stable(tree_state_r)
        |-> ##2 !res_learn) else $error("learning in blocking state");
    AST_LEARN_STATE: assert property (pkt_valid && in_st == ST_LEARN && !pkt_da_override && $stable(tree_state_r)
        |-> ##2 res_drop && res_learn) else $error("learning state misbehaves");
    AST_FWD_LEARN: assert property (pkt_valid && in_st == ST_FORWARD && $stable(tree_state_r)
        |-> ##2 res_learn) else $error("forwarding port not learning");
    AST_MISS_DROP: assert property (res_valid && res_member == '0 && $past(vlan_en) && $past(cfg_r[CFG_MBR_CHK])
        |-> res_drop) else $error("empty membership not dropped");
    AST_TAG_DISABLE: assert property (pkt_valid && cfg_r[CFG_TAG_DIS] && $stable(cfg_r)
        |=> ##1 res_vid == $past(port_default_vlan_id_r[s1_port_r])) else $error("port default vid not forced");
endmodule
`default_nettype wire

// ---- tb/svp_mac_model.sv ----
// svp_mac_model: port mac side, hands one parsed descriptor per call.
// assumes a free running core_clk; the caller checks the result.
`timescale 1ns/100ps
`default_nettype none
module svp_mac_model (
    input  wire logic  core_clk,
    input  wire logic  res_valid,
    output logic       pkt_valid,
    output logic [1:0] pkt_port,
    output logic       pkt_tagged,
    output logic [11:0] pkt_vid,
    output logic [2:0] pkt_pcp,
    output logic       pkt_is_ip,
    output logic [7:0] pkt_tos,
    output logic       pkt_da_hit,
    output logic       pkt_da_override
);
    logic [28:0] fld = '0;
    assign {pkt_port, pkt_tagged, pkt_vid, pkt_pcp, pkt_is_ip, pkt_tos, pkt_da_hit, pkt_da_override} = fld;
    initial pkt_valid = 1'b0;
    // fields flip once taken, so stale values never look held
    task automatic send(input logic [28:0] d);
        @(posedge core_clk);
        pkt_valid <= 1'b1;
        fld <= d;
        @(posedge core_clk);
        pkt_valid <= 1'b0;
        fld <= ~d;
        for (int i = 0; i < 5 && res_valid !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/svp_classifier_tb.sv ----
// svp_classifier_tb: register and packet sequences with expected results.
// assumes the classifier's own assertions watch the timing.
`timescale 1ns/100ps
`default_nettype none
module svp_classifier_tb;
    import svp_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata;
    logic pkt_valid, pkt_tagged, pkt_is_ip, pkt_da_hit, pkt_da_override, res_valid, res_drop, res_learn;
    logic [1:0] pkt_port, res_queue;
    logic [11:0] pkt_vid, res_vid;
    logic [2:0] pkt_pcp, res_prio, res_member, res_untag, res_egress;
    logic [7:0] pkt_tos;
    int num_errors = 0, compares = 0, cyc = 0;
    svp_classifier svp_classifier_inst (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pkt_valid, .pkt_port, .pkt_tagged, .pkt_vid, .pkt_pcp, .pkt_is_ip, .pkt_tos,
        .pkt_da_hit, .pkt_da_override, .res_valid, .res_drop, .res_prio, .res_queue, .res_vid,
        .res_member, .res_untag, .res_egress, .res_learn);
    svp_mac_model svp_mac_model_inst (.core_clk, .res_valid, .pkt_valid, .pkt_port, .pkt_tagged,
        .pkt_vid, .pkt_pcp, .pkt_is_ip, .pkt_tos, .pkt_da_hit, .pkt_da_override);
    initial forever #25 core_clk = ~core_clk;
    task automatic test_done;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // command then poll busy, bounded
    task automatic cmd(input logic [7:0] a, input logic [31:0] d);
        wr(a, d);
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            {reg_rd, reg_addr} <= {1'b1, REG_CMD_STATUS};
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1 if (reg_rdata[0] === 1'b0) break;
        end
        chk(reg_rdata[0], 0);
    endtask
    task automatic pk(input logic [1:0] p, input logic t, input logic [11:0] v, input logic [2:0] c,
        input logic ip, input logic [7:0] tos, input logic h, input logic o);
        svp_mac_model_inst.send({p, t, v, c, ip, tos, h, o});
        chk(res_valid, 1);
    endtask
    initial begin
        logic [31:0] v;
        v = '0;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(REG_TC_MAP, 32'h0000FA50);
        rd(REG_TREE_STATE, 32'h0);
        rd(8'hFC, 32'h0);
        for (int i = 0; i < 64; i++) begin
            wr(REG_DSCP_WDATA, 32'(i % 8));
            cmd(REG_DSCP_CMD, 32'h100 | i);
        end
        cmd(REG_DSCP_CMD, 32'h5);
        rd(REG_DSCP_RDATA, 32'h5);
        wr(REG_GLOBAL_CFG, 32'h1);
        for (int i = 0; i < 64; i += 9) begin
            pk(2'd0, i[0], 12'h5, 3'd0, 1'b1, 8'(i << 2) | 8'h3, 1'b1, 1'b0);
            chk(res_prio, i % 8);
            chk(res_queue, (i % 8) / 2);
        end
        for (int n = 0; n < 8; n++) v[3*n+:3] = 3'(7 - n);
        wr(REG_REGEN_P1, v);
        wr(REG_GLOBAL_CFG, 32'h2);
        for (int n = 0; n < 8; n++) begin
            pk(2'd1, 1'b1, 12'h5, 3'(n), 1'b0, 8'h0, 1'b1, 1'b0);
            chk(res_prio, 7 - n);
            pk(2'd0, 1'b1, 12'h5, 3'(n), 1'b0, 8'h0, 1'b1, 1'b0);
            chk(res_prio, n);
        end
        wr(REG_VLAN_WDATA, 32'h00073123);
        cmd(REG_VLAN_CMD, 32'h100);
        cmd(REG_VLAN_CMD, 32'h0);
        rd(REG_VLAN_RDATA, 32'h00073123);
        wr(REG_HYBRID, 32'h2);
        wr(REG_GLOBAL_CFG, 32'h18);
        pk(2'd0, 1'b1, 12'h123, 3'd0, 1'b0, 8'h0, 1'b1, 1'b0);
        chk({res_vid, res_member, res_drop}, {12'h123, 3'b011, 1'b0});
        chk(res_untag, 3'b010);
        chk(res_egress, 3'b010);
        rd(REG_LAST_RESULT, 32'h40);
        pk(2'd0, 1'b1, 12'h124, 3'd0, 1'b0, 8'h0, 1'b1, 1'b0);
        chk({res_member, res_drop}, 4'b0001);
        pk(2'd0, 1'b1, 12'hFFF, 3'd0, 1'b0, 8'h0, 1'b1, 1'b0);
        chk(res_drop, 1);
        wr(REG_GLOBAL_CFG, 32'h10);
        pk(2'd0, 1'b1, 12'h124, 3'd0, 1'b0, 8'h0, 1'b0, 1'b0);
        chk(res_drop, 1);
        pk(2'd0, 1'b0, 12'h123, 3'd0, 1'b0, 8'h0, 1'b1, 1'b0);
        chk(res_vid, 12'h1);
        pk(2'd0, 1'b1, 12'h000, 3'd0, 1'b0, 8'h0, 1'b1, 1'b0);
        chk(res_vid, 12'h1);
        wr(REG_VLAN_WDATA, 32'h00006123);
        cmd(REG_VLAN_CMD, 32'h112);
        cmd(REG_VLAN_CMD, 32'h114);
        pk(2'd2, 1'b0, 12'h0, 3'd0, 1'b0, 8'h0, 1'b1, 1'b0);
        chk({res_vid, res_prio, res_drop}, {12'h123, 3'd6, 1'b0});
        wr(REG_GLOBAL_CFG, 32'h14);
        pk(2'd0, 1'b1, 12'h123, 3'd0, 1'b0, 8'h0, 1'b1, 1'b0);
        chk(res_vid, 12'h1);
        wr(REG_GLOBAL_CFG, 32'h0);
        for (int s = 0; s < 4; s++) begin
            wr(REG_TREE_STATE, 32'(s << 2));
            pk(2'd1, 1'b0, 12'h0, 3'd0, 1'b0, 8'h0, 1'b1, 1'b0);
            chk({res_drop, res_learn}, {s != 0, s[0] == 1'b0});
            pk(2'd1, 1'b0, 12'h0, 3'd0, 1'b0, 8'h0, 1'b1, 1'b1);
            chk(res_drop, s == 3);
            pk(2'd0, 1'b0, 12'h0, 3'd0, 1'b0, 8'h0, 1'b1, 1'b0);
            chk(res_egress, {1'b1, s == 0, 1'b0});
            pk(2'd0, 1'b0, 12'h0, 3'd0, 1'b0, 8'h0, 1'b1, 1'b1);
            chk(res_egress, {1'b1, s != 3, 1'b0});
        end
        test_done();
    end
endmodule
`default_nettype wire
